/* File: acq_host_control_and_transfer_tb.sv */
// Self-checking testbench of the acquisition host control block.
`timescale 1ns/10ps
`default_nettype none
module acq_host_control_and_transfer_tb;
  import ahct_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic dev_reset = 1'b0;
  logic bus_cs_n = 1'b1;
  logic bus_rd_n = 1'b1;
  logic bus_wr_n = 1'b1;
  logic [2:0] bus_addr = 3'h0;
  logic [15:0] bus_data_in = 16'h0000;
  logic [15:0] bus_data_out;
  logic bus_data_oe, int_out, int_oe, data_ready, cal_start, conv_start, conv_valid, conv_ready;
  logic [15:0] conv_cmd;
  ahct_result_type conv_result;
  int n_fail = 0;
  int samples_checked = 0;
  int n_cal = 0;
  int n_conv = 0;
  logic [15:0] rv;
  logic [15:0] last_cmd, res_q0, res_q1;
  ////////////////////////////////////////////////////////////////////////////
  ahct_top #(.CAL_CYCLES(20)) DUT (.clk_sys(clk_sys), .arst_n(arst_n), .dev_reset(dev_reset),
    .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_addr(bus_addr),
    .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .int_out(int_out), .int_oe(int_oe), .data_ready(data_ready), .cal_start(cal_start),
    .conv_start(conv_start), .conv_cmd(conv_cmd), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .conv_result(conv_result));
  ahct_conv_model #(.LAT(3)) u_conv (.clk_sys(clk_sys), .arst_n(arst_n),
    .conv_start(conv_start), .conv_cmd(conv_cmd), .conv_ready(conv_ready),
    .conv_valid(conv_valid), .conv_result(conv_result));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (cal_start === 1'b1) n_cal++;
    if (conv_start === 1'b1) begin
      n_conv++;
      last_cmd = conv_cmd;
    end
    if (conv_valid === 1'b1 && conv_ready === 1'b1) begin
      res_q1 = res_q0;
      res_q0 = conv_result.data;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // Strobes are held well past the three-flop synchroniser on both levels.
  // One strobe only.
  task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    bus_addr = a;
    bus_data_in = d;
    bus_cs_n = 1'b0;
    bus_wr_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    bus_wr_n = 1'b1;
    bus_cs_n = 1'b1;
    bus_data_in = ~d;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic bus_rd(input logic [2:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    bus_addr = a;
    bus_cs_n = 1'b0;
    bus_rd_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    d = bus_data_out;
    chk_bit(bus_data_oe, 1'b1);
    bus_rd_n = 1'b1;
    bus_cs_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic sec_wr(input logic [15:0] x, input logic [15:0] d);
    bus_wr(A_INDEX, x);
    bus_wr(A_WIN0, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 2; i < 6; i++) begin
      bus_rd(3'(i), rv);
      chk_word(rv, 16'h0000);
    end
    @(negedge clk_sys);
    dev_reset = 1'b1;
    repeat (12) @(negedge clk_sys);
    chk_bit(int_out, 1'b0);
    chk_bit(int_oe, 1'b1);
    dev_reset = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic t_runerr;
    bus_wr(A_CTRL, 16'h0001);
    bus_rd(A_STAT, rv);
    chk_word(rv, 16'h0020);
    bus_wr(A_CTRL, 16'h0004);
    rv = 16'h0004;
    for (int i = 0; i < 10 && rv[C_SRST]; i++) bus_rd(A_CTRL, rv);
    chk_word(rv, 16'h0000);
    bus_rd(A_STAT, rv);
    chk_word(rv, 16'h0000);
  endtask
  task automatic t_cal;
    sec_wr(16'h0013, 16'h4000);
    bus_rd(A_WIN0, rv);
    chk_word(rv, 16'h4000 | CRIT_ONES);
    bus_wr(A_CTRL, 16'h0002);
    chk_word(16'(n_cal), 16'h0001);
    repeat (30) @(negedge clk_sys);
    bus_rd(A_STAT, rv);
    chk_word(rv, 16'h00C0);
    chk_bit(int_out, 1'b1);
    sec_wr(16'h0013, 16'hC000);
    chk_bit(int_out, 1'b0);
    chk_bit(int_oe, 1'b1);
    bus_wr(A_CTRL, 16'h0000);
    bus_rd(A_CTRL, rv);
    chk_word(rv, 16'h0002);
    bus_wr(A_CTRL, 16'h0002);
    chk_word(16'(n_cal), 16'h0002);
    repeat (30) @(negedge clk_sys);
    bus_wr(A_ACK, 16'h0040);
    bus_rd(A_STAT, rv);
    chk_word(rv, 16'h0000);
    chk_bit(int_oe, 1'b0);
  endtask
  task automatic t_seq;
    int base;
    base = n_conv;
    sec_wr(16'h0010, 16'h0005);
    bus_rd(A_WIN0, rv);
    chk_word(rv, 16'h0005);
    sec_wr(16'h0008, 16'h3000);
    sec_wr(16'h0009, 16'h8000);
    bus_wr(A_CTRL, 16'h0003);
    bus_rd(A_STAT, rv);
    chk_word(rv & 16'h001F, 16'h0010);
    chk_word(16'(n_conv - base), 16'h0000);
    bus_wr(A_ACK, 16'h0010);
    repeat (40) @(negedge clk_sys);
    bus_rd(A_STAT, rv);
    chk_word(rv & 16'h001F, 16'h0011);
    chk_word(16'(n_conv - base), 16'h0002);
    chk_word(last_cmd, 16'h8000);
    chk_bit(conv_ready, 1'b1);
    chk_bit(data_ready, 1'b1);
    bus_wr(A_ACK, 16'h0010);
    repeat (40) @(negedge clk_sys);
    bus_rd(A_STAT, rv);
    chk_word(rv & 16'h001F, 16'h0019);
  endtask
  task automatic t_dma;
    bus_wr(A_CTRL, 16'h0002);
    sec_wr(16'h0011, 16'hF000);
    sec_wr(16'h0013, 16'h0109);
    sec_wr(16'h0010, 16'h0400);
    sec_wr(16'h0008, 16'h5000);
    bus_wr(A_ACK, 16'h007F);
    bus_wr(A_CTRL, 16'h0019);
    repeat (1100) @(negedge clk_sys);
    chk_bit(data_ready, 1'b1);
    chk_bit(int_out, 1'b1);
    bus_rd(A_STAT, rv);
    chk_word(rv & 16'h001F, 16'h0005);
    bus_rd(A_WIN0, rv);
    chk_word(rv, {8'h00, res_q1[7:0]});
    bus_rd(A_WIN1, rv);
    chk_word(rv, {8'h00, res_q1[15:8]});
    bus_rd(A_WIN0, rv);
    chk_word(rv, {8'h00, res_q0[7:0]});
    bus_rd(A_WIN1, rv);
    chk_word(rv, {8'h00, res_q0[15:8]});
    chk_bit(data_ready, 1'b0);
    bus_rd(A_STAT, rv);
    chk_word(rv & 16'h0001, 16'h0000);
    bus_wr(A_CTRL, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_runerr();
    t_cal();
    t_seq();
    t_dma();
    stop_test();
  end
  // The whole sequence needs well under ten thousand cycles.
  initial begin
    #320000;
    n_fail++;
    stop_test();
  end
endmodule // acq_host_control_and_transfer_tb
`default_nettype wire

/* File: ahct_conv_model.sv */
// Behavioural converter model on the far side of the conversion interface.
`timescale 1ns/10ps
`default_nettype none
module ahct_conv_model
  import ahct_pkg::*;
#(
  parameter int LAT = 3
) (
  input  wire logic            clk_sys,
  input  wire logic            arst_n,
  input  wire logic            conv_start,
  input  wire logic [15:0]     conv_cmd,
  input  wire logic            conv_ready,
  output logic                 conv_valid,
  output ahct_result_type      conv_result
);
  int cnt;
  logic [15:0] seq;
  // A result is held until taken; between results the data lines toggle.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      seq <= 16'h0100;
      conv_valid <= 1'b0;
      conv_result <= '0;
    end else begin
      if (conv_valid && conv_ready) begin
        conv_valid <= 1'b0;
        conv_result <= ~conv_result;
      end else if (!conv_valid) begin
        conv_result <= ~conv_result;
      end
      if (conv_start) begin
        cnt <= LAT;
      end else if (cnt == 1) begin
        cnt <= 0;
        conv_valid <= 1'b1;
        conv_result <= {1'b0, seq ^ conv_cmd};
        seq <= seq + 16'h0001;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // ahct_conv_model
`default_nettype wire

/* File: ahct_pkg.sv */
// Package of constants and types for the acquisition host control block.
package ahct_pkg;

  // Primary register addresses on the parallel bus.
  localparam logic [2:0] A_WIN0  = 3'h0;
  localparam logic [2:0] A_WIN1  = 3'h1;
  localparam logic [2:0] A_INDEX = 3'h2;
  localparam logic [2:0] A_CTRL  = 3'h3;
  localparam logic [2:0] A_STAT  = 3'h4;
  localparam logic [2:0] A_SEQP  = 3'h5;
  localparam logic [2:0] A_ACK   = 3'h6;

  // Secondary register indices reached through the window registers.
  localparam logic [4:0] X_DRAM  = 5'h00;
  localparam logic [4:0] X_INSTR = 5'h08;
  localparam logic [4:0] X_TIMER = 5'h10;
  localparam logic [4:0] X_LIMA  = 5'h11;
  localparam logic [4:0] X_LIMB  = 5'h12;
  localparam logic [4:0] X_MASK  = 5'h13;

  // Control register fields.
  localparam int C_RUN   = 0;
  localparam int C_CAL   = 1;
  localparam int C_SRST  = 2;
  localparam int C_DMA   = 3;
  localparam int C_BYTE  = 4;
  localparam int C_AUTO_INDEX_INCREMENT = 5;

  // Status register fields; mask bit 8+n enables status bit n.
  localparam int S_DRDY  = 0;
  localparam int S_OVRG  = 1;
  localparam int S_ALRM  = 2;
  localparam int S_OVRN  = 3;
  localparam int S_PAUSE = 4;
  localparam int S_RUN_TIME_ERROR  = 5;
  localparam int S_CALIBRATION_COMPLETE  = 6;
  localparam int M_EN_LO = 8;
  localparam int M_POL   = 15;

  // Limit criteria fields and the unused bits that read as ones.
  localparam int K_GT_A = 0;
  localparam int K_GT_B = 1;
  localparam int K_AND  = 2;
  localparam int K_EN_A = 3;
  localparam int K_EN_B = 4;
  localparam logic [15:0] CRIT_ONES = 16'h00E0;

  // Instruction word fields and sequencing modes.
  localparam int I_LAST   = 15;
  localparam int I_LIMIT  = 14;
  localparam int I_MODE_H = 13;
  localparam int I_MODE_L = 11;
  localparam logic [2:0] MODE_TMO   = 3'h2;
  localparam logic [2:0] MODE_PAUSE = 3'h6;

  // Timing counts in internal clock cycles.
  localparam logic [2:0] SRST_CYCLES  = 3'h4;
  localparam int         CAL_CYCLES_D = 8260;

  typedef enum logic [2:0] {
    SQ_IDLE, SQ_FETCH, SQ_PAUSE, SQ_TMO, SQ_CONV, SQ_WAIT
  } ahct_seq_type;

  typedef struct packed {
    logic        ovr;
    logic [15:0] data;
  } ahct_result_type;

  typedef struct packed {
    logic        rst;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic [2:0]  addr;
    logic [15:0] data;
  } ahct_pins_type;

endpackage

/* File: ahct_skid2.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module ahct_skid2 #(
  parameter int W = 17
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic         v0;
    logic         v1;
    logic         rdy;
  } ahct_buf_state_type;

  ahct_buf_state_type s;
  ahct_buf_state_type n;

  always_comb begin
    n = s;
    if (s.v0 && out_ready) begin
      n.e0 = s.e1;
      n.v0 = s.v1;
      n.v1 = 1'b0;
    end
    if (in_valid && s.rdy) begin
      if (!n.v0) begin
        n.e0 = in_data;
        n.v0 = 1'b1;
      end else begin
        n.e1 = in_data;
        n.v1 = 1'b1;
      end
    end
    // Ready is registered, so it drops only once both entries hold words.
    n.rdy = !n.v1;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{e0: '0, e1: '0, v0: 1'b0, v1: 1'b0, rdy: 1'b1};
    end else begin
      s <= n;
    end
  end

  assign in_ready  = s.rdy;
  assign out_valid = s.v0;
  assign out_data  = s.e0;

endmodule // ahct_skid2
`default_nettype wire

/* File: ahct_top.sv */
// Host control, sequencing and data transfer logic of the acquisition block.
`timescale 1ns/10ps
`default_nettype none
//
// Function
// (R1) Host holds reset at least 10 cycles.
// (R2) Reset bit self-clears after 4 cycles.
// (R3) Calibrate bit starts calibration, then complete status.
// (R4) Calibrate bit stays one until reset.
// (R5) Each write with calibrate set recalibrates.
// (R6) Both resets clear the same register set.
// (R7) Reset keeps converter calibration, clears calibrate bit.
// (R8) Run without calibrate flags run-time error.
// (R9) Timer preset at index 10h, above 1.
// (R10) Timeout mode needs timer above conversion time.
// (R11) Host loads sign-extended limits and criteria.
// (R12) Status bit 7 ORs enabled conditions.
// (R13) Mask bit 15 selects pin polarity, drive.
// (R14) Pin active high by default, low in reset.
// (R15) Only enabled conditions reach summary and pin.
// (R16) Pause before conversion, resume on acknowledge.
// (R17) Data ready set; unacknowledged gives overrun.
// (R18) DMA mode drives request pin, byte order.
// (R19) DMA window reads advance and acknowledge.
// (R20) Data ready enable routes sequence end.
// (R21) Host never asserts both strobes outside reset.
// (R22) Host configures and clears before run.
// (R23) Criteria bits pick compare and combine.
// (R24) Run loads timer from preset.
// (R25) Acknowledge bits clear matching pending status.
module ahct_top
  import ahct_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_D
) (
  input  wire logic            clk_sys,
  input  wire logic            arst_n,
  input  wire logic            dev_reset,
  input  wire logic            bus_cs_n,
  input  wire logic            bus_rd_n,
  input  wire logic            bus_wr_n,
  input  wire logic [2:0]      bus_addr,
  input  wire logic [15:0]     bus_data_in,
  output logic [15:0]          bus_data_out,
  output logic                 bus_data_oe,
  output logic                 int_out,
  output logic                 int_oe,
  output logic                 data_ready,
  output logic                 cal_start,
  output logic                 conv_start,
  output logic [15:0]          conv_cmd,
  input  wire logic            conv_valid,
  output logic                 conv_ready,
  input  wire ahct_result_type conv_result
);

  localparam int CW = $clog2(CAL_CYCLES + 1);

  typedef struct packed {
    ahct_pins_type     s1;
    ahct_pins_type     s2;
    ahct_pins_type     s3;
    ahct_pins_type     pin;
    logic              wr_q;
    logic              rd_q;
    logic [15:0]       index;
    logic [15:0]       ctrl;
    logic [6:0]        status;
    logic [15:0]       mask_crit;
    logic [15:0]       preset;
    logic [15:0]       lim_a;
    logic [15:0]       lim_b;
    logic [7:0][15:0]  instr;
    logic [7:0][15:0]  dram;
    logic [CW-1:0]     cal_cnt;
    logic [2:0]        srst_cnt;
    ahct_seq_type      seq;
    logic [2:0]        op;
    logic [15:0]       timer;
    logic [2:0]        dma_ptr;
    logic [2:0]        dma_last;
    logic              dma_hi;
    logic              dma_pend;
    logic [15:0]       rdata;
    logic              data_oe;
    logic              int_out;
    logic              int_oe;
    logic              drdy;
    logic              conv_start;
    logic              cal_start;
    logic [15:0]       conv_cmd;
  } ahct_state_type;

  ahct_state_type  s;
  ahct_state_type  n;
  ahct_result_type res;
  logic            res_vld;
  logic            res_rdy;
  logic            wr_go;
  logic            rd_go;
  logic            do_clear;
  logic            pause_ack;
  logic            seq_end;
  logic            int_act;
  logic [6:0]      set;
  logic [6:0]      clr;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [15:0] sec_rd(input ahct_state_type st);
    logic [4:0] x;
    x = st.index[4:0];
    if (x[4:3] == X_DRAM[4:3]) return st.dram[x[2:0]];
    if (x[4:3] == X_INSTR[4:3]) return st.instr[x[2:0]];
    unique case (x)
      // (R24) Preset reads back.
      X_TIMER: return st.preset;
      X_LIMA:  return st.lim_a;
      X_LIMB:  return st.lim_b;
      X_MASK:  return st.mask_crit | CRIT_ONES;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic limit_hit(input logic [15:0] d, input ahct_state_type st);
    logic ha;
    logic hb;
    logic [15:0] k;
    k  = st.mask_crit;
    ha = k[K_GT_A] ? ($signed(d) > $signed(st.lim_a)) : ($signed(d) <= $signed(st.lim_a));
    hb = k[K_GT_B] ? ($signed(d) > $signed(st.lim_b)) : ($signed(d) <= $signed(st.lim_b));
    // (R23) Criteria combine.
    if (k[K_EN_A] && k[K_EN_B]) return k[K_AND] ? (ha && hb) : (ha || hb);
    return (k[K_EN_A] && ha) || (k[K_EN_B] && hb);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic        lo_first;
    logic        take_hi;
    logic        tmo;
    logic [15:0] wd;
    logic [15:0] w;
    n          = s;
    set        = 7'h00;
    clr        = 7'h00;
    pause_ack  = 1'b0;
    seq_end    = 1'b0;
    res_rdy    = 1'b0;
    tmo        = 1'b0;
    lo_first   = 1'b0;
    take_hi    = 1'b0;
    w          = 16'h0000;
    wd         = s.pin.data;
    n.conv_start = 1'b0;
    n.cal_start  = 1'b0;
    // Pins pass three flops; a change counts once the last two agree.
    n.s1  = ahct_pins_type'({dev_reset, bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_data_in});
    n.s2  = s.s1;
    n.s3  = s.s2;
    n.pin = ahct_pins_type'((s.s2 & s.s3) | (s.pin & (s.s2 | s.s3)));
    // (R21) Both strobes ignored.
    n.wr_q = !s.pin.cs_n && !s.pin.wr_n && s.pin.rd_n;
    n.rd_q = !s.pin.cs_n && !s.pin.rd_n && s.pin.wr_n;
    wr_go  = n.wr_q && !s.wr_q && !s.pin.rst;
    rd_go  = n.rd_q && !s.rd_q && !s.pin.rst;
    // (R12) Summary of enabled conditions.
    // (R20) Data ready enable routes.
    int_act = |(s.status & s.mask_crit[M_POL-1:M_EN_LO]);

    // (R24) Timer counts while running.
    if (s.seq != SQ_IDLE) begin
      if (s.timer == 16'h0001) begin
        n.timer = s.preset;
        tmo = 1'b1;
      end else if (s.timer != 16'h0000) begin
        n.timer = s.timer - 16'h0001;
      end
    end

    // (R3) Calibration duration.
    if (s.cal_cnt != '0) begin
      n.cal_cnt = s.cal_cnt - CW'(1);
      if (s.cal_cnt == CW'(1)) set[S_CALIBRATION_COMPLETE] = 1'b1;
    end
    if (s.srst_cnt != 3'h0) n.srst_cnt = s.srst_cnt - 3'h1;

    if (wr_go) begin
      unique case (s.pin.addr)
        A_INDEX: n.index = wd;
        A_CTRL: begin
          n.ctrl = wd;
          // (R4) Calibrate bit sticky.
          n.ctrl[C_CAL] = s.ctrl[C_CAL] | wd[C_CAL];
          // (R5) Fresh calibration start.
          if (wd[C_CAL]) begin
            n.cal_start = 1'b1;
            n.cal_cnt   = CW'(CAL_CYCLES);
          end
          // (R8) Run without calibration.
          if (wd[C_RUN] && !s.ctrl[C_CAL]) set[S_RUN_TIME_ERROR] = 1'b1;
          // (R2) Soft reset countdown.
          if (wd[C_SRST]) n.srst_cnt = SRST_CYCLES;
        end
        A_ACK: begin
          // (R25) Acknowledge clears pending.
          clr = wd[6:0];
          pause_ack = wd[S_PAUSE];
        end
        A_WIN0, A_WIN1: begin
          if (s.index[4:3] == X_INSTR[4:3]) n.instr[s.index[2:0]] = wd;
          unique case (s.index[4:0])
            X_TIMER: if (!s.ctrl[C_RUN]) n.preset = wd;
            X_LIMA:  n.lim_a = wd;
            X_LIMB:  n.lim_b = wd;
            X_MASK:  n.mask_crit = wd;
            default: ;
          endcase
          if (s.ctrl[C_AUTO_INDEX_INCREMENT]) n.index = s.index + 16'h0001;
        end
        default: ;
      endcase
    end

    if (rd_go) begin
      unique case (s.pin.addr)
        A_WIN0, A_WIN1: begin
          if (s.ctrl[C_DMA]) begin
            // (R18) Byte order select.
            lo_first = s.ctrl[C_BYTE];
            take_hi  = lo_first ? s.dma_hi : !s.dma_hi;
            w        = s.dram[s.dma_ptr];
            n.rdata  = take_hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
            n.dma_hi = !s.dma_hi;
            // (R19) Self-advance and acknowledge.
            if (s.dma_hi) begin
              n.dma_ptr = s.dma_ptr + 3'h1;
              if (s.dma_ptr == s.dma_last) begin
                n.dma_pend = 1'b0;
                n.dma_ptr  = 3'h0;
                clr[S_DRDY] = 1'b1;
              end
            end
          end else begin
            n.rdata = sec_rd(s);
            if (s.ctrl[C_AUTO_INDEX_INCREMENT]) n.index = s.index + 16'h0001;
          end
        end
        A_INDEX: n.rdata = s.index;
        A_CTRL:  n.rdata = s.ctrl;
        A_STAT:  n.rdata = {8'h00, int_act, s.status};
        A_SEQP:  n.rdata = {12'h000, s.seq != SQ_IDLE, s.op};
        default: n.rdata = 16'h0000;
      endcase
    end

    unique case (s.seq)
      SQ_IDLE: begin
        // Results arriving after a halt are dropped, not left stale.
        res_rdy = 1'b1;
        if (s.ctrl[C_RUN]) begin
          // (R24) Load on run entry.
          n.timer = s.preset;
          n.op    = 3'h0;
          n.seq   = SQ_FETCH;
        end
      end
      SQ_FETCH: begin
        if (s.instr[s.op][I_MODE_H:I_MODE_L] == MODE_PAUSE) begin
          // (R16) Pause before conversion.
          set[S_PAUSE] = 1'b1;
          n.seq = SQ_PAUSE;
        end else if (s.instr[s.op][I_MODE_H:I_MODE_L] == MODE_TMO) begin
          n.seq = SQ_TMO;
        end else begin
          n.seq = SQ_CONV;
        end
      end
      SQ_PAUSE: if (pause_ack) n.seq = SQ_CONV;
      SQ_TMO:   if (tmo) n.seq = SQ_CONV;
      SQ_CONV: begin
        n.conv_start = 1'b1;
        n.conv_cmd   = s.instr[s.op];
        n.seq        = SQ_WAIT;
      end
      SQ_WAIT: begin
        res_rdy = 1'b1;
        if (res_vld) begin
          n.dram[s.op] = res.data;
          if (res.ovr) set[S_OVRG] = 1'b1;
          if (s.instr[s.op][I_LIMIT] && limit_hit(res.data, s)) set[S_ALRM] = 1'b1;
          seq_end = s.instr[s.op][I_LAST] || (s.op == 3'h7);
          n.seq   = SQ_FETCH;
          n.op    = seq_end ? 3'h0 : s.op + 3'h1;
          if (seq_end) begin
            // (R17) Sequence end and overrun.
            set[S_DRDY] = 1'b1;
            if (s.status[S_DRDY] && !clr[S_DRDY]) set[S_OVRN] = 1'b1;
            n.dma_pend = s.ctrl[C_DMA];
            n.dma_ptr  = 3'h0;
            n.dma_hi   = 1'b0;
            n.dma_last = s.op;
          end
        end
      end
      default: n.seq = SQ_IDLE;
    endcase
    if (!s.ctrl[C_RUN]) n.seq = SQ_IDLE;

    // A new event wins over an acknowledge in the same cycle.
    n.status = (s.status & ~clr) | set;

    // (R6) Identical reset effect.
    do_clear = s.pin.rst || (s.srst_cnt == 3'h1);
    if (do_clear) begin
      // (R7) Calibration data untouched.
      n.index     = 16'h0000;
      n.ctrl      = 16'h0000;
      n.status    = 7'h00;
      n.mask_crit = 16'h0000;
      n.seq       = SQ_IDLE;
      n.op        = 3'h0;
      n.cal_cnt   = '0;
      n.srst_cnt  = 3'h0;
      n.dma_pend  = 1'b0;
      n.dma_ptr   = 3'h0;
      n.dma_hi    = 1'b0;
    end

    // (R14) Low during reset.
    if (s.pin.rst) begin
      n.int_out = 1'b0;
      n.int_oe  = 1'b1;
    // (R13) Open drain when low active.
    end else if (s.mask_crit[M_POL]) begin
      n.int_out = 1'b0;
      n.int_oe  = int_act;
    end else begin
      // (R15) Only enabled conditions.
      n.int_out = int_act;
      n.int_oe  = 1'b1;
    end
    // (R18) DMA request pin.
    n.drdy    = s.ctrl[C_DMA] ? s.dma_pend : s.status[S_DRDY];
    n.data_oe = n.rd_q && !s.pin.rst;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  ahct_skid2 #(.W($bits(ahct_result_type))) u_buf (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .in_data   (conv_result),
    .out_valid (res_vld),
    .out_ready (res_rdy),
    .out_data  (res)
  );

  assign bus_data_out = s.rdata;
  assign bus_data_oe  = s.data_oe;
  assign int_out      = s.int_out;
  assign int_oe       = s.int_oe;
  assign data_ready   = s.drdy;
  assign cal_start    = s.cal_start;
  assign conv_start   = s.conv_start;
  assign conv_cmd     = s.conv_cmd;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic wd_srst;
  assign wd_srst = s.pin.data[C_SRST] && (s.srst_cnt == 3'h0);

  sequence s_ctrl_wr;
    wr_go && (s.pin.addr == A_CTRL) && !do_clear;
  endsequence

  property p_srst_clear;
    s_ctrl_wr ##0 wd_srst |=> s.ctrl[C_SRST] [*4] ##1 !s.ctrl[C_SRST];
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("reset bit timing"); // (R2)

  property p_cal_sticky;
    s.ctrl[C_CAL] && !do_clear |=> s.ctrl[C_CAL];
  endproperty
  a_cal_sticky: assert property (p_cal_sticky) else $error("cal bit lost"); // (R4)

  property p_cal_start;
    s_ctrl_wr ##0 s.pin.data[C_CAL] |=> cal_start && (s.cal_cnt == CW'(CAL_CYCLES));
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("no calibration start"); // (R5)

  property p_cal_done;
    (s.cal_cnt == CW'(1)) && !do_clear |=> s.status[S_CALIBRATION_COMPLETE];
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("no cal complete"); // (R3)

  property p_run_err;
    s_ctrl_wr ##0 (s.pin.data[C_RUN] && !s.ctrl[C_CAL]) |=> s.status[S_RUN_TIME_ERROR];
  endproperty
  a_run_err: assert property (p_run_err) else $error("no run error"); // (R8)

  property p_int_reset;
    s.pin.rst |=> int_oe && !int_out;
  endproperty
  a_int_reset: assert property (p_int_reset) else $error("int pin in reset"); // (R14)

  property p_int_od;
    !s.pin.rst && s.mask_crit[M_POL] |=> !int_out && (int_oe == $past(int_act));
  endproperty
  a_int_od: assert property (p_int_od) else $error("open drain drive"); // (R13)

  property p_int_masked;
    !s.pin.rst && !s.mask_crit[M_POL] |=> int_out == $past(int_act);
  endproperty
  a_int_masked: assert property (p_int_masked) else $error("int not masked"); // (R15)

  property p_pause_hold;
    s.seq == SQ_PAUSE && !pause_ack && s.ctrl[C_RUN] && !do_clear |=> s.seq == SQ_PAUSE;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause left early"); // (R16)

  property p_overrun;
    s.seq == SQ_WAIT && res_vld && seq_end && s.status[S_DRDY] && !clr[S_DRDY] && !do_clear
      |=> s.status[S_OVRN] && s.status[S_DRDY];
  endproperty
  a_overrun: assert property (p_overrun) else $error("no overrun"); // (R17)

  property p_timer_load;
    s.seq == SQ_IDLE && s.ctrl[C_RUN] && !do_clear |=> s.timer == $past(s.preset);
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("timer not loaded"); // (R24)

endmodule // ahct_top
`default_nettype wire
